//--- rtl/lcc_pkg.sv
// constants and types for the link cycle control register bank
//
// Contract
// - cap priority requests per fairness interval
// - fairness register upper 24 bits read zero
// - external select: roll over on external input
// - internal select: roll over after 3072 ticks
// - cycle master emits cycle start each rollover
// - non-master syncs to received cycle starts
// - overlong cycle event clears cycle master flag
// - master set ignored while overlong event set
// - count enable advances offset per tick
// - count enable clear holds offset
// - phy packets stored when flag and context
// - phy packet flag ignores self-id packets
// - accept self-id flag accepts self-id packets
// - filter lock forces every sync filter bit
// - unlocked sync filter bits follow software
// - filter lock set-only, cleared by reset
// - unused link control bits read zero
`default_nettype none

package lcc_pkg;

    // ==========================================================
    // register map (byte addresses)
    // ==========================================================
    localparam logic [11:0] FAIR_OFS     = 12'h0DC;
    localparam logic [11:0] LC_SET_OFS   = 12'h0E0;
    localparam logic [11:0] LC_CLR_OFS   = 12'h0E4;
    localparam logic [31:0] FAIR_RST     = 32'h00000000;

    // ==========================================================
    // link control field positions
    // ==========================================================
    localparam int EXT_SEL_BIT  = 22;
    localparam int MASTER_BIT   = 21;
    localparam int CNT_EN_BIT   = 20;
    localparam int PHY_PKT_BIT  = 10;
    localparam int SELFID_BIT   = 9;
    localparam int LOCK_BIT     = 6;
    localparam int PRI_REQ_W    = 8;

    // ==========================================================
    // cycle timer timing
    // ==========================================================
    localparam longint CYC_PERIOD_NS = 125000;
    localparam longint TICK_HZ       = 24576000;
    localparam longint CYC_TICKS =
        (CYC_PERIOD_NS * TICK_HZ) / 64'd1000000000;
    localparam int     OFS_W         = 12;
    localparam logic [OFS_W-1:0] OFS_LAST =
        OFS_W'(CYC_TICKS - 1);
    localparam logic [OFS_W-1:0] OFS_RST  = 12'h000;

    // number of isochronous receive contexts
    localparam int IR_CTX = 4;

    // ==========================================================
    // types
    // ==========================================================
    // link control flags as one carrier
    typedef struct packed {
        logic ext_cycle_select;
        logic cycle_master_flag;
        logic cycle_offset_count_enable;
        logic accept_phy_packets;
        logic accept_selfid;
        logic sync_filter_lock;
    } lcc_flags_t;

    localparam lcc_flags_t FLAGS_RST = 6'h00;

endpackage : lcc_pkg

`default_nettype wire

//--- rtl/lcc_link_cycle_control_regs.sv
// link cycle control registers with cycle timer and rx gating
`timescale 1ns/1ps
`default_nettype none

module lcc_link_cycle_control_regs
    import lcc_pkg::*;
(
    // apb slave
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,

    // pins: tick clock and external cycle input
    input  wire logic                clk24_in,
    input  wire logic                ext_cycle_input,

    // interrupt event level and received cycle start
    input  wire logic                overlong_cycle_event,
    input  wire logic                cycle_start_rx,
    output logic                     cycle_start_tx,
    output logic                     cycle_rollover,
    output logic [OFS_W-1:0]         cycle_offset,

    // fairness arbitration
    input  wire logic                fairness_start,
    input  wire logic                pri_req_want,
    output logic                     pri_req_grant,

    // receive gating
    input  wire logic                async_receive_req_en,
    input  wire logic                phy_pkt_in,
    input  wire logic                selfid_pkt_in,
    output logic                     phy_pkt_store,
    output logic                     selfid_pkt_accept,

    // isochronous receive sync filter bits
    input  wire logic [IR_CTX-1:0]   sync_filter_sw,
    output logic [IR_CTX-1:0]        sync_filter_bit
);

    // ==========================================================
    // declarations
    // ==========================================================
    lcc_flags_t           flags_ff;      // link control flags
    lcc_flags_t           nxt_flags;
    logic [PRI_REQ_W-1:0] pri_lim_ff;    // fairness limit
    logic [PRI_REQ_W-1:0] nxt_pri_lim;
    logic [PRI_REQ_W-1:0] pri_cnt_ff;    // grants this interval
    logic [PRI_REQ_W-1:0] nxt_pri_cnt;

    // apb read path
    logic [31:0]          rdata_ff;      // registered read data
    logic [31:0]          nxt_rdata;

    // cycle timer state
    logic [OFS_W-1:0]     ofs_ff;        // cycle timer offset
    logic [OFS_W-1:0]     nxt_ofs;
    logic                 roll_ff;       // rollover pulse
    logic                 nxt_roll;
    logic                 cst_ff;        // cycle start pulse
    logic                 nxt_cst;
    logic                 ovl_ff;        // last overlong level

    // pin synchronisers
    logic [2:0]           tck_sync_ff;   // tick pin synchroniser
    logic [2:0]           ext_sync_ff;   // ext pin synchroniser

    // decoded strobes
    logic                 acc_wr;        // write access phase
    logic                 mapped;        // address is decoded
    logic                 tick;          // one tick edge seen
    logic                 ext_evt;       // one ext edge seen
    logic                 ovl_rise;      // overlong event rises
    logic [31:0]          lc_view;       // link control readback

    // ==========================================================
    // apb decode
    // ==========================================================
    // address match over the three words
    always_comb
    begin
        mapped = (paddr == FAIR_OFS)   ||
                 (paddr == LC_SET_OFS) ||
                 (paddr == LC_CLR_OFS);
    end

    // pready never drops, so no access stalls;
    // unmapped words answer with pslverr
    // zero wait states; data comes from the setup-cycle flop
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign acc_wr  = psel & penable & pwrite & mapped;
    assign prdata  = rdata_ff;

    // link control word, unused positions stay zero
    always_comb
    begin
        lc_view              = 32'h00000000;
        lc_view[EXT_SEL_BIT] = flags_ff.ext_cycle_select;
        lc_view[MASTER_BIT]  = flags_ff.cycle_master_flag;
        lc_view[CNT_EN_BIT]  = flags_ff.cycle_offset_count_enable;
        lc_view[PHY_PKT_BIT] = flags_ff.accept_phy_packets;
        lc_view[SELFID_BIT]  = flags_ff.accept_selfid;
        lc_view[LOCK_BIT]    = flags_ff.sync_filter_lock;
    end

    // read data captured in setup so it is stable in access
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                FAIR_OFS:
                    // only the low byte is real
                    nxt_rdata = {24'h000000, pri_lim_ff};
                LC_SET_OFS, LC_CLR_OFS:
                    nxt_rdata = lc_view;
                // unmapped reads give zero
                default:
                    nxt_rdata = 32'h00000000;
            endcase
        end
    end

    // read data register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_ff <= 32'h00000000;
        else
            rdata_ff <= nxt_rdata;
    end

    // ==========================================================
    // fairness control
    // ==========================================================
    // limit register and per-interval grant count
    always_comb
    begin
        nxt_pri_lim = pri_lim_ff;
        nxt_pri_cnt = pri_cnt_ff;

        if (acc_wr && paddr == FAIR_OFS)
            nxt_pri_lim = pwdata[PRI_REQ_W-1:0];
        // a new interval wins over a grant
        if (fairness_start)
            nxt_pri_cnt = '0;
        else if (pri_req_grant)
            nxt_pri_cnt = pri_cnt_ff + 8'h01;
    end

    // combinational, so the phy sees it at once;
    // the count stops at the limit, never wraps
    // a request goes to the phy only while under the limit
    assign pri_req_grant = pri_req_want &&
                           (pri_cnt_ff < pri_lim_ff);

    // fairness registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pri_lim_ff <= FAIR_RST[PRI_REQ_W-1:0];
            pri_cnt_ff <= '0;
        end
        else
        begin
            pri_lim_ff <= nxt_pri_lim;
            pri_cnt_ff <= nxt_pri_cnt;
        end
    end

    // ==========================================================
    // link control flags
    // ==========================================================
    // only a new event clears; a standing one blocks sets
    // overlong event edge against last sampled level
    assign ovl_rise = overlong_cycle_event & ~ovl_ff;

    // set word sets, clear word clears, zero bits do nothing
    always_comb
    begin
        nxt_flags = flags_ff;

        if (acc_wr && paddr == LC_SET_OFS)
        begin
            // ones in the set word raise flags
            if (pwdata[EXT_SEL_BIT])
                nxt_flags.ext_cycle_select = 1'b1;
            // master refused while the event stands
            if (pwdata[MASTER_BIT] && !overlong_cycle_event)
                nxt_flags.cycle_master_flag = 1'b1;
            if (pwdata[CNT_EN_BIT])
                nxt_flags.cycle_offset_count_enable = 1'b1;
            if (pwdata[PHY_PKT_BIT])
                nxt_flags.accept_phy_packets = 1'b1;
            if (pwdata[SELFID_BIT])
                nxt_flags.accept_selfid = 1'b1;
            if (pwdata[LOCK_BIT])
                nxt_flags.sync_filter_lock = 1'b1;
        end
        else if (acc_wr && paddr == LC_CLR_OFS)
        begin
            // ones in the clear word drop flags
            if (pwdata[EXT_SEL_BIT])
                nxt_flags.ext_cycle_select = 1'b0;
            if (pwdata[MASTER_BIT])
                nxt_flags.cycle_master_flag = 1'b0;
            if (pwdata[CNT_EN_BIT])
                nxt_flags.cycle_offset_count_enable = 1'b0;
            if (pwdata[PHY_PKT_BIT])
                nxt_flags.accept_phy_packets = 1'b0;
            if (pwdata[SELFID_BIT])
                nxt_flags.accept_selfid = 1'b0;
            // lock is not clearable here
        end

        // placed last, so it beats a set in one cycle
        // the event drops master status as it appears
        if (ovl_rise)
            nxt_flags.cycle_master_flag = 1'b0;
    end

    // an event high at release clears nothing new
    // flag registers; reset is the only way out of the lock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags_ff <= FLAGS_RST;
            ovl_ff   <= 1'b0;
        end
        else
        begin
            flags_ff <= nxt_flags;
            ovl_ff   <= overlong_cycle_event;
        end
    end

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    // stage one may be metastable; logic reads only
    // the second and third stages
    // two flops, then a third only for edge detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tck_sync_ff <= 3'h0;
            ext_sync_ff <= 3'h0;
        end
        else
        begin
            tck_sync_ff <= {tck_sync_ff[1:0], clk24_in};
            ext_sync_ff <= {ext_sync_ff[1:0], ext_cycle_input};
        end
    end

    // each tick or event lasts one pclk cycle
    // rising edges, read from the second and third stages
    assign tick    = tck_sync_ff[1] & ~tck_sync_ff[2];
    assign ext_evt = ext_sync_ff[1] & ~ext_sync_ff[2];

    // ==========================================================
    // cycle timer
    // ==========================================================
    // offset count, rollover and cycle start generation
    always_comb
    begin
        nxt_ofs  = ofs_ff;
        nxt_roll = 1'b0;
        nxt_cst  = 1'b0;

        // branch order is the priority: disabled,
        // received start, external edge, tick
        if (!flags_ff.cycle_offset_count_enable)
        begin
            // counting stopped: offset holds
            nxt_ofs = ofs_ff;
        end
        else if (!flags_ff.cycle_master_flag && cycle_start_rx)
        begin
            // received cycle start realigns us
            nxt_ofs = OFS_RST;
        end
        else if (flags_ff.ext_cycle_select && ext_evt)
        begin
            // external edge ends the cycle
            nxt_ofs  = OFS_RST;
            nxt_roll = 1'b1;
        end
        else if (tick)
        begin
            if (!flags_ff.ext_cycle_select && ofs_ff == OFS_LAST)
            begin
                // internal count reached its end
                nxt_ofs  = OFS_RST;
                nxt_roll = 1'b1;
            end
            else
            begin
                // external mode wraps at the field width
                // one step per tick
                nxt_ofs = ofs_ff + 12'h001;
            end
        end

        // a master announces every rollover
        nxt_cst = nxt_roll & flags_ff.cycle_master_flag;
    end

    // cycle timer registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ofs_ff  <= OFS_RST;
            roll_ff <= 1'b0;
            cst_ff  <= 1'b0;
        end
        else
        begin
            ofs_ff  <= nxt_ofs;
            roll_ff <= nxt_roll;
            cst_ff  <= nxt_cst;
        end
    end

    // outputs come straight from the timer flops
    assign cycle_offset   = ofs_ff;
    assign cycle_rollover = roll_ff;
    assign cycle_start_tx = cst_ff;

    // ==========================================================
    // receive gating
    // ==========================================================
    // plain gates: a flag change acts at once
    // phy packets need flag and an enabled request context
    assign phy_pkt_store = phy_pkt_in &
                           flags_ff.accept_phy_packets &
                           async_receive_req_en;
    // self-id acceptance ignores the phy packet flag
    assign selfid_pkt_accept = selfid_pkt_in &
                               flags_ff.accept_selfid;

    // ==========================================================
    // isochronous sync filter override
    // ==========================================================
    // the lock beats software in every context
    // one lane per receive context
    genvar ctx;
    generate
        for (ctx = 0; ctx < IR_CTX; ctx++)
        begin : g_sync
            // lock forces one, else software value passes
            assign sync_filter_bit[ctx] =
                flags_ff.sync_filter_lock |
                sync_filter_sw[ctx];
        end
    endgenerate

endmodule : lcc_link_cycle_control_regs

`default_nettype wire

//--- test/lcc_regs_properties.sv
// port checker for the link cycle control register bank
`timescale 1ns/1ps
`default_nettype none
module lcc_regs_properties
    import lcc_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              fairness_start,
    input wire logic              pri_req_grant,
    input wire logic              async_receive_req_en,
    input wire logic              phy_pkt_in,
    input wire logic              phy_pkt_store,
    input wire logic              selfid_pkt_in,
    input wire logic              selfid_pkt_accept,
    input wire logic [IR_CTX-1:0] sync_filter_sw,
    input wire logic [IR_CTX-1:0] sync_filter_bit,
    input wire logic              cycle_start_tx,
    input wire logic              cycle_rollover,
    input wire logic [OFS_W-1:0]  cycle_offset
);
    // ==========================================================
    // shadow copies of limit, grant count, lock and enable
    // ==========================================================
    logic       wr;        // write taken this cycle
    logic [7:0] lim_ff;    // request limit
    logic [7:0] nxt_lim;
    logic [7:0] cnt_ff;    // grants in this interval
    logic [7:0] nxt_cnt;
    logic       lock_ff;   // filter lock, set only
    logic       nxt_lock;
    logic       en_ff;     // offset count enable
    logic       nxt_en;
    assign wr = psel && penable && pwrite;
    // next shadow values from taken writes
    always_comb
    begin
        nxt_lim  = (wr && paddr == FAIR_OFS) ? pwdata[7:0] : lim_ff;
        nxt_cnt  = fairness_start ? 8'h00 : cnt_ff + 8'(pri_req_grant);
        nxt_lock = lock_ff | (wr && paddr == LC_SET_OFS && pwdata[LOCK_BIT]);
        nxt_en   = en_ff;
        if (wr && pwdata[CNT_EN_BIT])
            nxt_en = (paddr == LC_SET_OFS) ? 1'b1
                   : (paddr == LC_CLR_OFS) ? 1'b0 : en_ff;
    end
    // shadows clear on reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {lim_ff, cnt_ff, lock_ff, en_ff} <= '0;
        else
            {lim_ff, cnt_ff, lock_ff, en_ff} <= {nxt_lim, nxt_cnt, nxt_lock, nxt_en};
    end
    // ==========================================================
    // properties
    // ==========================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // read access phase
    sequence rd_acc;
        psel && penable && !pwrite;
    endsequence
    AST_FAIR_ZERO:
        assert property (rd_acc ##0 (paddr == FAIR_OFS) |-> prdata[31:8] == 24'h0)
        else $error("fairness high bits not zero");
    AST_LC_ZERO:
        assert property (rd_acc ##0 (paddr != FAIR_OFS)
            |-> (prdata & ~32'h00700640) == 32'h0) else $error("unused bits set");
    AST_GRANT_CAP:
        assert property (pri_req_grant && !fairness_start |-> cnt_ff < lim_ff)
        else $error("grant beyond limit");
    AST_PHY_STORE:
        assert property (phy_pkt_store |-> phy_pkt_in && async_receive_req_en)
        else $error("phy store without packet or context");
    AST_SELFID:
        assert property (selfid_pkt_accept |-> selfid_pkt_in)
        else $error("self-id accept without packet");
    AST_LOCKED:
        assert property (lock_ff |-> sync_filter_bit == {IR_CTX{1'b1}})
        else $error("locked filter bit low");
    AST_SW_PASS:
        assert property (!lock_ff |-> sync_filter_bit == sync_filter_sw)
        else $error("filter bit differs from software");
    AST_HOLD:
        assert property (!en_ff |=> $stable(cycle_offset))
        else $error("offset moved while disabled");
    AST_TX_ROLL:
        assert property (cycle_start_tx |-> cycle_rollover)
        else $error("cycle start without rollover");
    AST_ROLL_ZERO:
        assert property (cycle_rollover |-> cycle_offset == OFS_RST)
        else $error("rollover without zeroed offset");
endmodule : lcc_regs_properties
bind lcc_link_cycle_control_regs lcc_regs_properties i_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .fairness_start, .pri_req_grant, .async_receive_req_en, .phy_pkt_in,
    .phy_pkt_store, .selfid_pkt_in, .selfid_pkt_accept, .sync_filter_sw,
    .sync_filter_bit, .cycle_start_tx, .cycle_rollover, .cycle_offset
);
`default_nettype wire

//--- test/lcc_phy_model.sv
// far-side model: tick oscillator and external cycle pin
`timescale 1ns/1ps
`default_nettype none
module lcc_phy_model
#(
    parameter real HALF_NS = 20.345  // half period of the tick clock
)
(
    input  wire logic ext_go,
    output logic      clk24_in,
    output logic      ext_cycle_input
);
    // free-running tick oscillator, unrelated to pclk
    initial clk24_in = 1'b0;
    always #(HALF_NS) clk24_in = ~clk24_in;
    // one external cycle pulse, wide enough for the synchroniser
    initial ext_cycle_input = 1'b0;
    always @(posedge ext_go)
    begin
        ext_cycle_input = 1'b1;
        #40;
        ext_cycle_input = 1'b0;
    end
endmodule : lcc_phy_model
`default_nettype wire

//--- test/lcc_link_cycle_control_regs_tb_top.sv
// testbench for the link cycle control register bank
`timescale 1ns/1ps
`default_nettype none
module lcc_link_cycle_control_regs_tb_top
    import lcc_pkg::*;
;
    logic              pclk = 1'b0;
    logic              presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata;
    logic              clk24_in, ext_cycle_input, ext_go;
    logic              overlong_cycle_event, cycle_start_rx, cycle_start_tx;
    logic              cycle_rollover, fairness_start, pri_req_want;
    logic              pri_req_grant, async_receive_req_en, phy_pkt_in;
    logic              selfid_pkt_in, phy_pkt_store, selfid_pkt_accept;
    logic [OFS_W-1:0]  cycle_offset;
    logic [IR_CTX-1:0] sync_filter_sw, sync_filter_bit;
    logic [1:0]        e;          // expected packet outputs
    logic [32:0]       expq[$];    // notes {pslverr, prdata} of reads
    int                err_total, num_checks, cyc, n, lim, seed = 42038;
    // ==========================================================
    // design, far side and clock
    // ==========================================================
    lcc_link_cycle_control_regs i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .clk24_in, .ext_cycle_input,
        .overlong_cycle_event, .cycle_start_rx, .cycle_start_tx,
        .cycle_rollover, .cycle_offset, .fairness_start, .pri_req_want,
        .pri_req_grant, .async_receive_req_en, .phy_pkt_in, .selfid_pkt_in,
        .phy_pkt_store, .selfid_pkt_accept, .sync_filter_sw, .sync_filter_bit
    );
    lcc_phy_model i_phy (.ext_go, .clk24_in, .ext_cycle_input);
    always #2 pclk = ~pclk;
    // ==========================================================
    // tasks
    // ==========================================================
    task chk(input logic [32:0] g, input logic [32:0] x);
        num_checks++;
        if (g !== x)
        begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    // one apb transfer, entered just after a rising edge
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask : apb
    // read with its expected result noted first
    task rd(input logic [11:0] a, input logic [32:0] x);
        expq.push_back(x);
        apb(a, 1'b0, 32'h0);
    endtask : rd
    // count offset changes up to the next rollover
    task wait_roll(input logic tx);
        logic [OFS_W-1:0] p;
        n = 0;
        p = cycle_offset;
        do
        begin
            @(negedge pclk);
            n += int'(cycle_offset !== p);
            p = cycle_offset;
        end
        while (cycle_rollover !== 1'b1);
        chk(33'(cycle_start_tx), 33'(tx));
        @(posedge pclk);
    endtask : wait_roll
    task complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    // read results checked against the oldest note
    always @(posedge pclk)
    begin
        if (psel && penable && !pwrite && pready)
            chk({pslverr, prdata}, expq.size() ? expq.pop_front() : 33'h1);
    end
    // hang guard
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            err_total++;
            complete_run();
        end
    end
    // ==========================================================
    // main sequence
    // ==========================================================
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ext_go} = '0;
        {overlong_cycle_event, cycle_start_rx, fairness_start} = '0;
        {pri_req_want, async_receive_req_en, phy_pkt_in, selfid_pkt_in} = '0;
        sync_filter_sw = IR_CTX'($random(seed));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(FAIR_OFS, 33'h0);
        rd(LC_CLR_OFS, 33'h0);
        rd(12'h0F0, 33'h100000000);
        chk(33'(sync_filter_bit), 33'(sync_filter_sw));
        apb(FAIR_OFS, 1'b1, 32'hFFFFFFFF);
        rd(FAIR_OFS, 33'hFF);
        apb(LC_SET_OFS, 1'b1, 32'hFFFFFFFF);
        rd(LC_CLR_OFS, 33'h00700640);
        chk(33'(sync_filter_bit), 33'hF);
        apb(LC_CLR_OFS, 1'b1, 32'hFFFFFFFF);
        rd(LC_SET_OFS, 33'h40);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(LC_SET_OFS, 33'h0);
        $display("test registers done");
        for (int k = 0; k < 2; k++)
        begin
            lim = ($random(seed) & 7) + 1;
            apb(FAIR_OFS, 1'b1, 32'(lim));
            fairness_start <= 1'b1;
            @(posedge pclk);
            fairness_start <= 1'b0;
            pri_req_want <= 1'b1;
            n = 0;
            repeat (20) @(negedge pclk) n += int'(pri_req_grant === 1'b1);
            @(posedge pclk);
            pri_req_want <= 1'b0;
            chk(33'(n), 33'(lim));
        end
        $display("test fairness done");
        overlong_cycle_event <= 1'b1;
        apb(LC_SET_OFS, 1'b1, 32'h00200000);
        rd(LC_SET_OFS, 33'h0);
        overlong_cycle_event <= 1'b0;
        apb(LC_SET_OFS, 1'b1, 32'h00200000);
        rd(LC_SET_OFS, 33'h00200000);
        overlong_cycle_event <= 1'b1;
        @(posedge pclk);
        rd(LC_SET_OFS, 33'h0);
        overlong_cycle_event <= 1'b0;
        $display("test master flag done");
        for (int i = 0; i < 8; i++)
        begin
            apb(LC_CLR_OFS, 1'b1, 32'h00000600);
            apb(LC_SET_OFS, 1'b1, 32'(i[1:0]) << 9);
            async_receive_req_en <= i[2];
            {phy_pkt_in, selfid_pkt_in} <= 2'b11;
            e = {i[1] & i[2], i[0]};
            @(negedge pclk);
            chk(33'({phy_pkt_store, selfid_pkt_accept}), 33'(e));
            @(posedge pclk);
            {phy_pkt_in, selfid_pkt_in} <= 2'b00;
        end
        $display("test receive gating done");
        apb(LC_SET_OFS, 1'b1, 32'h00100000);
        repeat (300) @(posedge pclk);
        cycle_start_rx <= 1'b1;
        @(posedge pclk);
        cycle_start_rx <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        chk(33'(cycle_offset < 12'h002), 33'h1);
        @(posedge pclk);
        apb(LC_SET_OFS, 1'b1, 32'h00200000);
        wait_roll(1'b1);
        wait_roll(1'b1);
        chk(33'(n), 33'd3072);
        apb(LC_CLR_OFS, 1'b1, 32'h00300000);
        lim = cycle_offset;
        repeat (100) @(posedge pclk);
        #1;
        chk(33'(cycle_offset), 33'(lim));
        @(posedge pclk);
        for (int m = 0; m < 2; m++)
        begin
            apb(LC_SET_OFS, 1'b1, 32'h00500000 | (32'(m) << 21));
            repeat (20) @(posedge pclk);
            ext_go <= 1'b1;
            wait_roll(m[0]);
            ext_go <= 1'b0;
            chk(33'(n < 12), 33'h1);
        end
        $display("test cycle timer done");
        complete_run();
    end
endmodule : lcc_link_cycle_control_regs_tb_top
`default_nettype wire
